//--- shared/rds_pkg.sv
// constants shared by the relay driver serial command block
//------------------------------------------------------------------------------
// What this block does
// [RL1] Two register groups, control and diagnosis, are reached through serial command frames.
// [RL2] At power-on reset every register bit takes its defined default value.
// [RL3] A frame holds the command in bits 15:14, the pointer in bits 10:8 and data in bits 7:0.
// [RL4] The master drives bits 13 to 11 as zero, and the device ignores them.
// [RL5] Command 00 only returns the diagnosis word and changes no register.
// [RL6] Command 01 captures the pointed register and shifts it out in the next frame.
// [RL7] Command 10 returns every register to its default value.
// [RL8] Command 11 stores the data byte into the pointed register.
// [RL9] The data byte carries the value written to or read from the pointed register.
// [RL10] The diagnosis word holds a 2-bit status for channel n at bits 2n+1 and 2n.
// [RL11] The status codes are 00 short to ground, 01 open load, 10 overload, 11 normal.
// [RL12] The answer to a read is 01, three zeros, the echoed pointer, then the register data.
// [RL13] A read takes two frames: the request, then the frame that carries the answer.
// [RL14] The command sent in the answer frame is decoded and executed as usual.
// [RL15] Defaults apply on any reset, and the input mapping register defaults to 08 hex.
// [RL16] After power-up the third parallel input drives output channel three.
// [RL17] Writes to the read-only output state register or to pointer 000 change nothing.
//------------------------------------------------------------------------------
package rds_pkg;

  //----------------------------------------------------------------------------
  // frame layout
  //----------------------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CMD_HI     = 15;
  localparam int CMD_LO     = 14;
  localparam int PTR_HI     = 10;
  localparam int PTR_LO     = 8;
  localparam int DATA_HI    = 7;
  localparam int DATA_LO    = 0;
  localparam int CHANNELS   = 8;
  localparam int PAR_INPUTS = 3;

  localparam logic [4:0] CNT_FULL = 5'h10;  // bits in a complete frame

  // command codes
  localparam logic [1:0] CMD_DIAG  = 2'h0;
  localparam logic [1:0] CMD_READ  = 2'h1;
  localparam logic [1:0] CMD_RESET = 2'h2;
  localparam logic [1:0] CMD_WRITE = 2'h3;

  // header of a read answer
  localparam logic [1:0] ANS_TAG  = 2'h1;
  localparam logic [2:0] ANS_FILL = 3'h0;

  // channel diagnosis codes
  localparam logic [1:0] DIAG_SHORT_GND = 2'h0;
  localparam logic [1:0] DIAG_OPEN_LOAD = 2'h1;
  localparam logic [1:0] DIAG_OVERLOAD  = 2'h2;
  localparam logic [1:0] DIAG_NORMAL    = 2'h3;

  //----------------------------------------------------------------------------
  // register pointers and defaults
  //----------------------------------------------------------------------------
  localparam logic [2:0] PTR_UNUSED        = 3'h0;
  localparam logic [2:0] PTR_INPUT_MAPPING = 3'h1;
  localparam logic [2:0] PTR_BULB_CFG      = 3'h2;
  localparam logic [2:0] PTR_OVERLOAD_CFG  = 3'h3;
  localparam logic [2:0] PTR_OVERTEMP_CFG  = 3'h4;
  localparam logic [2:0] PTR_SLEW_CFG      = 3'h5;
  localparam logic [2:0] PTR_OUTPUT_STATE  = 3'h6;
  localparam logic [2:0] PTR_OUTPUT_CTRL   = 3'h7;

  localparam logic [7:0] RST_INPUT_MAPPING = 8'h08;
  localparam logic [7:0] RST_OTHER         = 8'h00;

  typedef enum logic [1:0] {RDS_IDLE, RDS_FRAME, RDS_EXEC} rds_state_e;

endpackage : rds_pkg

//--- rtl/rds_spi_shift.sv
// serial shifter: frame detection, receive and transmit shift registers
`timescale 1ns/1ps
module rds_spi_shift
  import rds_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        si,
  input  wire logic [15:0] tx_word,
  output logic             so_o,
  output logic             so_oe,
  output logic             frame_start,
  output logic             frame_end,
  output logic [4:0]       bit_cnt,
  output logic [15:0]      rx_word
);

  logic       sclk_q_r;
  logic       cs_q_r;
  logic [15:0] tx_r;

  //----------------------------------------------------------------------------
  // edge detection on the sampled pins
  //----------------------------------------------------------------------------
  wire cs_fall   = cs_q_r & ~cs_n;
  wire cs_rise   = ~cs_q_r & cs_n;
  wire sclk_rise = ~cs_n & sclk & ~sclk_q_r;
  wire sclk_fall = ~cs_n & ~sclk & sclk_q_r;

  assign frame_start = cs_fall;
  assign frame_end   = cs_rise;

  // data out on rising edge, data in on falling edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclk_q_r <= 1'b0;
      cs_q_r   <= 1'b1;
      tx_r     <= 16'h0000;
      rx_word  <= 16'h0000;
      bit_cnt  <= 5'h00;
      so_o     <= 1'b0;
      so_oe    <= 1'b0;
    end else begin
      sclk_q_r <= sclk;
      cs_q_r   <= cs_n;
      so_oe    <= ~cs_n;                     // drive only inside a frame
      if (cs_fall) begin
        tx_r    <= tx_word;
        bit_cnt <= 5'h00;
        so_o    <= 1'b0;
      end else begin
        if (sclk_rise) begin
          so_o <= tx_r[FRAME_BITS-1];        // msb first
          tx_r <= {tx_r[14:0], 1'b0};
        end
        if (sclk_fall) begin
          rx_word <= {rx_word[14:0], si};
          if (bit_cnt != 5'h1f)
            bit_cnt <= bit_cnt + 5'h01;      // saturates on overlong frames
        end
      end
    end
  end

endmodule : rds_spi_shift

//--- rtl/rds_reg_file.sv
// configuration register file with pointer access and bulk default load
`timescale 1ns/1ps
module rds_reg_file
  import rds_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic       load_defaults,
  input  wire logic [2:0] ptr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] output_state,
  output logic [7:0]      rdata,
  output logic [7:0]      input_mapping,
  output logic [7:0]      bulb_overload_cfg,
  output logic [7:0]      overload_behaviour_cfg,
  output logic [7:0]      overtemp_behaviour_cfg,
  output logic [7:0]      slew_rate_cfg,
  output logic [7:0]      output_control
);

  logic [7:0] regs_r [0:7];

  // default value of a pointer
  function automatic logic [7:0] reg_default(input logic [2:0] p);
    reg_default = (p == PTR_INPUT_MAPPING) ? RST_INPUT_MAPPING : RST_OTHER;  // [RL15]
  endfunction : reg_default

  // only the writable pointers hold storage
  function automatic logic writable(input logic [2:0] p);
    writable = (p != PTR_UNUSED) && (p != PTR_OUTPUT_STATE);
  endfunction : writable

  //----------------------------------------------------------------------------
  // storage, one generate slice per pointer
  //----------------------------------------------------------------------------
  for (genvar g = 0; g < 8; g++) begin : g_reg
    always_ff @(posedge sys_clk) begin
      if (!rst_n || load_defaults || !writable(3'(g)))
        regs_r[g] <= reg_default(3'(g));   // [RL2] [RL7]
      else if (wr_en && ptr == 3'(g))
        regs_r[g] <= wdata;                // [RL8] [RL17]
    end
  end

  // read mux; the output state register reflects live channel state
  assign rdata = (ptr == PTR_OUTPUT_STATE) ? output_state : regs_r[ptr];  // [RL1]

  assign input_mapping          = regs_r[PTR_INPUT_MAPPING];
  assign bulb_overload_cfg      = regs_r[PTR_BULB_CFG];
  assign overload_behaviour_cfg = regs_r[PTR_OVERLOAD_CFG];
  assign overtemp_behaviour_cfg = regs_r[PTR_OVERTEMP_CFG];
  assign slew_rate_cfg          = regs_r[PTR_SLEW_CFG];
  assign output_control         = regs_r[PTR_OUTPUT_CTRL];

endmodule : rds_reg_file

//--- rtl/rds_top.sv
// top of the relay driver serial command interpreter
`timescale 1ns/1ps
module rds_top
  import rds_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // serial port pins
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       si,
  output logic            so_o,
  output logic            so_oe,
  // parallel inputs, third_parallel_input is bit 2
  input  wire logic [2:0] par_in,
  // per-channel fault indications from the power stages
  input  wire logic [7:0] short_gnd,
  input  wire logic [7:0] open_load,
  input  wire logic [7:0] overload,
  // channel drive and configuration towards the power stages
  output logic [7:0]      chan_on,
  output logic [7:0]      bulb_cfg,
  output logic [7:0]      overload_cfg,
  output logic [7:0]      overtemp_cfg,
  output logic [7:0]      slew_cfg
);

  //----------------------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------------------
  rds_state_e  state_r;
  rds_state_e  state_nxt;
  logic        read_pend_r;
  logic [15:0] read_ans_r;
  logic [15:0] diag_word;
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  logic [4:0]  bit_cnt;
  logic        frame_start;
  logic        frame_end;
  logic [7:0]  rdata;
  logic [7:0]  input_mapping;
  logic [7:0]  bulb_w;
  logic [7:0]  ovl_w;
  logic [7:0]  ovt_w;
  logic [7:0]  slew_w;
  logic [7:0]  output_control;
  logic [7:0]  chan_nxt;
  logic [7:0]  chan_on_r;

  // status code of one channel, short wins over overload over open load
  function automatic logic [1:0] diag_code(input logic sg, input logic ol, input logic ov);
    if (sg)
      diag_code = DIAG_SHORT_GND;
    else if (ov)
      diag_code = DIAG_OVERLOAD;
    else if (ol)
      diag_code = DIAG_OPEN_LOAD;
    else
      diag_code = DIAG_NORMAL;
  endfunction : diag_code

  // parallel input that a mapped channel follows
  function automatic logic [1:0] chan_input(input int n);
    case (n)
      0, 4:    chan_input = 2'h0;
      1, 5:    chan_input = 2'h1;
      default: chan_input = 2'h2;
    endcase
  endfunction : chan_input

  //----------------------------------------------------------------------------
  // serial shifter
  //----------------------------------------------------------------------------
  rds_spi_shift u_shift (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .cs_n        (cs_n),
    .sclk        (sclk),
    .si          (si),
    .tx_word     (tx_word),
    .so_o        (so_o),
    .so_oe       (so_oe),
    .frame_start (frame_start),
    .frame_end   (frame_end),
    .bit_cnt     (bit_cnt),
    .rx_word     (rx_word)
  );

  //----------------------------------------------------------------------------
  // frame decode
  //----------------------------------------------------------------------------
  // bits 13:11 are not looked at
  wire [1:0] rx_cmd   = rx_word[CMD_HI:CMD_LO];     // [RL3] [RL4]
  wire [2:0] rx_ptr   = rx_word[PTR_HI:PTR_LO];     // [RL3]
  wire [7:0] rx_data  = rx_word[DATA_HI:DATA_LO];   // [RL3] [RL9]
  wire       full     = (bit_cnt == CNT_FULL);
  wire       exec     = (state_r == RDS_EXEC);
  wire       do_write = exec && (rx_cmd == CMD_WRITE);  // [RL8]
  wire       do_reset = exec && (rx_cmd == CMD_RESET);  // [RL7]
  wire       do_read  = exec && (rx_cmd == CMD_READ);   // [RL6]

  //----------------------------------------------------------------------------
  // register file
  //----------------------------------------------------------------------------
  rds_reg_file u_regs (
    .sys_clk                (sys_clk),
    .rst_n                  (rst_n),
    .wr_en                  (do_write),
    .load_defaults          (do_reset),
    .ptr                    (rx_ptr),
    .wdata                  (rx_data),
    .output_state           (chan_on_r),
    .rdata                  (rdata),
    .input_mapping          (input_mapping),
    .bulb_overload_cfg      (bulb_w),
    .overload_behaviour_cfg (ovl_w),
    .overtemp_behaviour_cfg (ovt_w),
    .slew_rate_cfg          (slew_w),
    .output_control         (output_control)
  );

  //----------------------------------------------------------------------------
  // diagnosis word and transmit selection
  //----------------------------------------------------------------------------
  for (genvar n = 0; n < CHANNELS; n++) begin : g_diag
    // channel_diag_pair of channel n
    assign diag_word[2*n+1:2*n] = diag_code(short_gnd[n], open_load[n], overload[n]);  // [RL10] [RL11]
  end

  // a pending read answer replaces the diagnosis word for one frame
  assign tx_word = read_pend_r ? read_ans_r : diag_word;  // [RL5] [RL13]

  //----------------------------------------------------------------------------
  // channel drive: control bit or mapped parallel input
  //----------------------------------------------------------------------------
  for (genvar n = 0; n < CHANNELS; n++) begin : g_chan
    // input_assign_bit n picks the parallel input for channel n
    assign chan_nxt[n] = input_mapping[n] ? par_in[chan_input(n)]  // [RL16]
                                          : output_control[n];
  end

  //----------------------------------------------------------------------------
  // frame state machine
  //----------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RDS_IDLE: begin
        if (frame_start)
          state_nxt = RDS_FRAME;
      end
      RDS_FRAME: begin
        if (frame_end)
          state_nxt = full ? RDS_EXEC : RDS_IDLE;  // short or long frames are dropped
      end
      RDS_EXEC: begin
        state_nxt = frame_start ? RDS_FRAME : RDS_IDLE;  // [RL14]
      end
      default: begin
        state_nxt = RDS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      state_r <= RDS_IDLE;
    else
      state_r <= state_nxt;
  end

  //----------------------------------------------------------------------------
  // read answer capture and hand-over to the next frame
  //----------------------------------------------------------------------------
  // a new read in the answer frame arms the following frame again
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      read_pend_r <= 1'b0;
      read_ans_r  <= 16'h0000;
    end else if (do_read) begin
      read_pend_r <= 1'b1;                                   // [RL6] [RL13]
      read_ans_r  <= {ANS_TAG, ANS_FILL, rx_ptr, rdata};     // [RL12] [RL9]
    end else if (frame_start) begin
      read_pend_r <= 1'b0;                                   // answer consumed
    end
  end

  //----------------------------------------------------------------------------
  // registered outputs
  //----------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chan_on_r    <= 8'h00;
      bulb_cfg     <= RST_OTHER;
      overload_cfg <= RST_OTHER;
      overtemp_cfg <= RST_OTHER;
      slew_cfg     <= RST_OTHER;
    end else begin
      chan_on_r    <= chan_nxt;
      bulb_cfg     <= bulb_w;
      overload_cfg <= ovl_w;
      overtemp_cfg <= ovt_w;
      slew_cfg     <= slew_w;
    end
  end

  assign chan_on = chan_on_r;

endmodule : rds_top

//--- tb/rds_top_assertions.sv
// concurrent checks on the serial command interpreter top
`timescale 1ns/1ps
module rds_top_assertions
  import rds_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       si,
  input wire logic       so_o,
  input wire logic       so_oe,
  input wire logic [7:0] short_gnd,
  input wire logic [7:0] open_load,
  input wire logic [7:0] overload,
  input wire logic [7:0] chan_on,
  input wire logic [7:0] bulb_cfg,
  input wire logic [7:0] overload_cfg,
  input wire logic [7:0] overtemp_cfg,
  input wire logic [7:0] slew_cfg
);
  logic        cs_q, sclk_q, pend_r;
  logic [4:0]  cnt;
  logic [2:0]  pptr_r;
  logic [15:0] sh, so_sh;
  // frame decode seen from the pins
  wire logic        sfall   = sclk_q && !sclk && !cs_n;
  wire logic        done    = cs_n && !cs_q && cnt == CNT_FULL;
  wire logic [1:0]  cmd     = sh[15:14];
  wire logic [31:0] cfg_all = {bulb_cfg, overload_cfg, overtemp_cfg, slew_cfg};
  wire logic [1:0]  ch0     = short_gnd[0] ? DIAG_SHORT_GND : overload[0] ? DIAG_OVERLOAD :
                              open_load[0] ? DIAG_OPEN_LOAD : DIAG_NORMAL;
  // shift both data lines on each falling serial clock inside a frame
  always_ff @(posedge sys_clk) begin
    cs_q   <= !rst_n || cs_n;
    sclk_q <= sclk;
    if (!cs_n && cs_q) cnt <= 5'h00;
    else if (sfall) cnt <= cnt + 5'h01;
    if (sfall) sh <= {sh[14:0], si};
    if (sfall) so_sh <= {so_sh[14:0], so_o};
    if (!rst_n) pend_r <= 1'b0;
    else if (cs_n && !cs_q) pend_r <= done && cmd == CMD_READ;
    if (cs_n && !cs_q) pptr_r <= sh[10:8];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_bulb;
    done && cmd == CMD_WRITE && sh[10:8] == PTR_BULB_CFG;
  endsequence
  sequence s_answer;
    done && pend_r;
  endsequence
  a_cfg_reset: assert property ($rose(rst_n) |-> cfg_all == 32'h0000_0000 && chan_on == 8'h00)
    else $error("outputs not cleared by reset");
  a_oe_follow: assert property (1'b1 |=> so_oe == !$past(cs_n))
    else $error("output enable does not follow select");
  a_diag_keeps: assert property (done && cmd == CMD_DIAG |=> $stable(cfg_all) [*5])
    else $error("diagnosis frame changed a register");
  a_write_lands: assert property (s_wr_bulb |-> ##[1:5] bulb_cfg == sh[7:0])
    else $error("write did not reach the register");
  a_reset_cmd: assert property (done && cmd == CMD_RESET |-> ##[1:5] cfg_all == 32'h0000_0000)
    else $error("reset command left a register set");
  a_short_ignored: assert property (cs_n && !cs_q && cnt != CNT_FULL |=> $stable(cfg_all) [*5])
    else $error("short frame was executed");
  a_read_header: assert property (s_answer |-> so_sh[15:8] == {ANS_TAG, ANS_FILL, pptr_r})
    else $error("read answer header wrong");
  a_diag_code: assert property (done && !pend_r |-> so_sh[1:0] == ch0)
    else $error("channel zero diagnosis wrong");
endmodule : rds_top_assertions

//--- tb/rds_master_model.sv
// host side serial master, mode 1, msb first
`timescale 1ns/1ps
module rds_master_model (
  input  wire logic        sys_clk,
  output logic             cs_n,
  output logic             sclk,
  output logic             si,
  input  wire logic        so_o,
  input  wire logic        so_oe,
  output logic             rx_valid,
  output logic [15:0]      rx_word
);
  // idle pins
  initial begin
    {cs_n, sclk, si, rx_valid} = 4'h8;
    rx_word = 16'h0000;
  end
  // one frame of nb bits; only a full frame reports what came back
  task automatic frame(input logic [15:0] w, input int nb);
    cs_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    for (int i = 15; i > 15 - nb; i--) begin
      si = (i > 10 && i < 14) ? 1'b0 : w[i];
      sclk = 1'b1;
      repeat (4) @(negedge sys_clk);
      rx_word[i] = so_oe ? so_o : 1'bx;
      sclk = 1'b0;
      repeat (4) @(negedge sys_clk);
    end
    repeat (6) @(negedge sys_clk);
    cs_n = 1'b1;
    si = ~si;
    rx_valid = (nb == 16);
    @(negedge sys_clk);
    rx_valid = 1'b0;
    repeat (9) @(negedge sys_clk);
  endtask : frame
endmodule : rds_master_model

//--- tb/test_rds_top.sv
// self-checking bench for the relay driver serial command top
`timescale 1ns/1ps
module test_rds_top;
  import rds_pkg::*;
  logic        sys_clk, rst_n, cs_n, sclk, si, so_o, so_oe, rx_valid, pend;
  logic [2:0]  par_in, pend_ptr;
  logic [7:0]  short_gnd, open_load, overload, chan_on, pend_dat;
  logic [7:0]  bulb_cfg, overload_cfg, overtemp_cfg, slew_cfg;
  logic [7:0]  regs [8];
  logic [15:0] rx_word;
  logic [15:0] exp_q [$];
  int          num_errors = 0;
  int          checks     = 0;

  rds_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .si(si),
    .so_o(so_o), .so_oe(so_oe), .par_in(par_in), .short_gnd(short_gnd),
    .open_load(open_load), .overload(overload), .chan_on(chan_on), .bulb_cfg(bulb_cfg),
    .overload_cfg(overload_cfg), .overtemp_cfg(overtemp_cfg), .slew_cfg(slew_cfg));
  rds_master_model m (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so_o(so_o),
    .so_oe(so_oe), .rx_valid(rx_valid), .rx_word(rx_word));

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // expected drive from the bench's own register copy, expected diagnosis from the fault inputs
  function automatic logic [7:0] chan_exp();
    logic [7:0] c;
    for (int n = 0; n < 8; n++)
      c[n] = regs[1][n] ? par_in[(n % 4 == 3) ? 2 : n % 4] : regs[7][n];
    return c;
  endfunction : chan_exp
  function automatic logic [15:0] diag_exp();
    logic [15:0] d;
    for (int n = 0; n < 8; n++)
      d[2*n +: 2] = short_gnd[n] ? DIAG_SHORT_GND : overload[n] ? DIAG_OVERLOAD :
                    open_load[n] ? DIAG_OPEN_LOAD : DIAG_NORMAL;
    return d;
  endfunction : diag_exp
  task automatic set_defaults();
    foreach (regs[i]) regs[i] = (i == 1) ? RST_INPUT_MAPPING : RST_OTHER;
  endtask : set_defaults

  // comparisons and verdict
  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: byte %h, expected %h", $time, g, e);
    end
  endtask : cmp8
  task automatic cmp16(input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: word %h, expected %h", $time, g, e);
    end
  endtask : cmp16
  task automatic end_sim();
    $display("checks %0d, num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic check_outs();
    cmp8(regs[2], bulb_cfg);
    cmp8(regs[3], overload_cfg);
    cmp8(regs[4], overtemp_cfg);
    cmp8(regs[5], slew_cfg);
    cmp8(chan_exp(), chan_on);
  endtask : check_outs

  // one frame: note the expected answer, send, then update the copy
  task automatic send(input logic [1:0] c, input logic [2:0] p, input logic [7:0] d,
                      input int nb);
    logic [7:0] v;
    v = (p == PTR_UNUSED) ? 8'h00 : (p == PTR_OUTPUT_STATE) ? chan_exp() : regs[p];
    if (nb == 16) exp_q.push_back(pend ? {ANS_TAG, ANS_FILL, pend_ptr, pend_dat} : diag_exp());
    m.frame({c, 3'h0, p, d}, nb);
    pend = (nb == 16) && (c == CMD_READ);
    pend_ptr = p;
    pend_dat = v;
    if (nb == 16 && c == CMD_RESET) set_defaults();
    if (nb == 16 && c == CMD_WRITE && p != PTR_UNUSED && p != PTR_OUTPUT_STATE) regs[p] = d;
    check_outs();
  endtask : send

  // take the oldest note whenever a word comes back
  always @(posedge sys_clk) begin
    if (rx_valid) cmp16(exp_q.pop_front(), rx_word);
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    end_sim();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    par_in = 3'h4;
    {short_gnd, open_load, overload} = 24'h00_0000;
    pend = 1'b0;
    set_defaults();
    void'($urandom(23));
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    check_outs();
    par_in = 3'h3;
    repeat (2) @(negedge sys_clk);
    check_outs();
    for (int p = 0; p < 8; p++) send(CMD_READ, 3'(p), 8'h00, 16);
    par_in = 3'($urandom);
    for (int p = 0; p < 8; p++) send(CMD_WRITE, 3'(p), 8'($urandom), 16);
    for (int p = 0; p < 8; p++) send(CMD_READ, 3'(p), 8'h00, 16);
    send(CMD_READ, PTR_SLEW_CFG, 8'h00, 16);
    send(CMD_WRITE, PTR_SLEW_CFG, 8'h5a, 16);
    send(CMD_READ, PTR_SLEW_CFG, 8'h00, 16);
    {short_gnd, overload, open_load} = 24'h11_3377;
    send(CMD_DIAG, 3'h0, 8'h00, 16);
    repeat (4) begin
      {short_gnd, open_load, overload} = 24'($urandom);
      send(CMD_DIAG, 3'($urandom), 8'($urandom), 16);
    end
    send(CMD_READ, PTR_INPUT_MAPPING, 8'h00, 16);
    send(CMD_RESET, 3'h0, 8'h00, 16);
    send(CMD_READ, PTR_INPUT_MAPPING, 8'h00, 16);
    send(CMD_READ, PTR_OUTPUT_CTRL, 8'h00, 16);
    send(CMD_WRITE, PTR_OUTPUT_CTRL, 8'hff, 15);
    // mid-run reset drops a pending read answer and restores the defaults
    send(CMD_WRITE, PTR_BULB_CFG, 8'h3c, 16);
    send(CMD_READ, PTR_BULB_CFG, 8'h00, 16);
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    set_defaults();
    pend = 1'b0;
    repeat (2) @(negedge sys_clk);
    check_outs();
    send(CMD_DIAG, 3'h0, 8'h00, 16);
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge sys_clk);
    if (exp_q.size() != 0) num_errors++;
    end_sim();
  end
endmodule : test_rds_top

bind rds_top rds_top_assertions chk (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n),
  .sclk(sclk), .si(si), .so_o(so_o), .so_oe(so_oe), .short_gnd(short_gnd),
  .open_load(open_load), .overload(overload), .chan_on(chan_on), .bulb_cfg(bulb_cfg),
  .overload_cfg(overload_cfg), .overtemp_cfg(overtemp_cfg), .slew_cfg(slew_cfg));
